// *** core/obc_pkg.sv ***
package obc_pkg;
   localparam int OBC_BYTE_W = 8;
   localparam logic [7:0] OBC_ERASED = 8'hFF;
   localparam int OBC_SEL_W = 1;
   localparam logic OBC_SEL_BYTE0 = 1'h0;
   localparam logic OBC_SEL_BYTE1 = 1'h1;
   localparam int OBC_B0_IRQMAP = 1;
   localparam int OBC_B0_PROTECT = 0;
   localparam int OBC_B1_CF_OFF = 7;
   localparam int OBC_B1_OSC_HI = 6;
   localparam int OBC_B1_OSC_LO = 4;
   localparam int OBC_B1_LVD_HI = 3;
   localparam int OBC_B1_LVD_LO = 2;
   localparam int OBC_B1_WATCHDOG_HALT_RESET = 1;
   localparam int OBC_B1_WATCHDOG_SOFTWARE_MODE = 0;
   localparam logic [5:0] OBC_B0_RSVD = 6'h3F;
   localparam logic [2:0] OBC_OSC_EXT_CLK = 3'h7;
   localparam logic [2:0] OBC_OSC_INT_RC = 3'h6;
   localparam logic [1:0] OBC_OSC_EXT_RC_HI = 2'h2;
   localparam logic [2:0] OBC_OSC_LP = 3'h3;
   localparam logic [2:0] OBC_OSC_MP = 3'h2;
   localparam logic [2:0] OBC_OSC_MS = 3'h1;
   localparam logic [2:0] OBC_OSC_HS = 3'h0;
   localparam logic [1:0] OBC_LVD_OFF = 2'h3;
   localparam logic [1:0] OBC_LVD_HIGH = 2'h2;
   localparam logic [1:0] OBC_LVD_MED = 2'h1;
   localparam logic [1:0] OBC_LVD_LOW = 2'h0;
   typedef enum logic [2:0] {
      OBC_CLK_EXT, OBC_CLK_INT_RC, OBC_CLK_EXT_RC, OBC_CLK_LP, OBC_CLK_MP, OBC_CLK_MS,
      OBC_CLK_HS
   } obc_clk_src_t;
   typedef enum logic [1:0] {OBC_LV_OFF, OBC_LV_HIGH, OBC_LV_MED, OBC_LV_LOW} obc_lvd_t;
endpackage : obc_pkg

// *** core/obc_option_byte_config_decoder.sv ***
`timescale 1ns/100ps
// Overview of operation
// - option bytes reachable only in programming mode
// - unprogrammed bytes read back as FFh
// - map bit routes port B,C to vector one
// - otherwise port C shares vector zero with A
// - protect bit blocks external program memory reads
// - clearing protect erases program memory, not options
// - byte1 bit7 low enables clock filter
// - byte1 bits6:4 select main oscillator
// - byte1 bits3:2 select low-voltage threshold
// - byte1 bit1 requests reset on watchdog halt
// - byte1 bit0 picks hardware or software watchdog
// - rom variant uses fixed factory option values
module obc_option_byte_config_decoder
   import obc_pkg::*;
#(
   parameter bit ROM_VARIANT = 1'b0,
   parameter logic [7:0] ROM_BYTE0 = 8'hFE,
   parameter logic [7:0] ROM_BYTE1 = 8'hEF
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic prog_mode,
   input wire logic prog_sel,
   input wire logic prog_wr,
   input wire logic [7:0] prog_wdata,
   output logic [7:0] prog_rdata,
   output logic prog_rvalid,
   input wire logic [7:0] port_a_irq,
   input wire logic [7:0] port_b_irq,
   input wire logic [5:0] port_c_irq,
   output logic ext_irq_vector_zero,
   output logic ext_irq_vector_one,
   input wire logic ext_mem_read_req,
   output logic ext_mem_read_grant,
   output logic mem_erase_req,
   output logic clock_filter_enable,
   output obc_clk_src_t oscillator_select,
   output obc_lvd_t low_voltage_threshold_select,
   output logic watchdog_halt_reset,
   output logic watchdog_hw_always_on
);
   // factory bytes must keep the reserved bits high, as a programmed part would
   if (ROM_VARIANT && ROM_BYTE0[7:2] != OBC_B0_RSVD) begin : g_bad_rom_byte0
      $error("rom byte 0 reserved bits must be ones");
   end

   logic rst_meta_reg;
   logic rst_sync_reg;
   logic [1:0] mode_sync_reg;
   logic [1:0] sel_sync_reg;
   logic [1:0] wr_sync_reg;
   logic wr_prev_reg;
   // data bus is not gray coded: the tool must hold it steady before the strobe
   logic [7:0] wdata_s1_reg;
   logic [7:0] wdata_s2_reg;
   logic [7:0] user_option_byte_zero_reg;
   logic [7:0] user_option_byte_one_reg;
   logic [7:0] byte0;
   logic [7:0] byte1;
   logic wr_pulse;
   logic prog_active;

   // one decode of the select pin shared by write, erase and read paths
   function automatic logic obc_is_byte0(input logic sel);
      return sel == OBC_SEL_BYTE0;
   endfunction : obc_is_byte0

   // 10x is tested first since a plain case item cannot hold a don't-care
   function automatic obc_clk_src_t obc_osc_decode(input logic [2:0] code);
      if (code[2:1] == OBC_OSC_EXT_RC_HI)
         return OBC_CLK_EXT_RC;
      case (code)
         OBC_OSC_EXT_CLK: return OBC_CLK_EXT;
         OBC_OSC_INT_RC: return OBC_CLK_INT_RC;
         OBC_OSC_LP: return OBC_CLK_LP;
         OBC_OSC_MP: return OBC_CLK_MP;
         OBC_OSC_MS: return OBC_CLK_MS;
         OBC_OSC_HS: return OBC_CLK_HS;
         // unreachable; external clock is the blank-part choice
         default: return OBC_CLK_EXT;
      endcase
   endfunction : obc_osc_decode

   function automatic obc_lvd_t obc_lvd_decode(input logic [1:0] code);
      case (code)
         OBC_LVD_OFF: return OBC_LV_OFF;
         OBC_LVD_HIGH: return OBC_LV_HIGH;
         OBC_LVD_MED: return OBC_LV_MED;
         OBC_LVD_LOW: return OBC_LV_LOW;
         default: return OBC_LV_OFF;
      endcase
   endfunction : obc_lvd_decode

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // pins from the programming tool are asynchronous to ref_clk
   always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         mode_sync_reg <= 2'h0;
         sel_sync_reg <= 2'h0;
         wr_sync_reg <= 2'h0;
         wr_prev_reg <= 1'b0;
         wdata_s1_reg <= 8'h00;
         wdata_s2_reg <= 8'h00;
      end else begin
         mode_sync_reg <= {mode_sync_reg[0], prog_mode};
         sel_sync_reg <= {sel_sync_reg[0], prog_sel};
         wr_sync_reg <= {wr_sync_reg[0], prog_wr};
         wr_prev_reg <= wr_sync_reg[1];
         wdata_s1_reg <= prog_wdata;
         wdata_s2_reg <= wdata_s1_reg;
      end
   end

   // rom parts ignore the tool entirely, so the port stays shut there
   assign prog_active = mode_sync_reg[1] && !ROM_VARIANT;
   assign wr_pulse = wr_sync_reg[1] && !wr_prev_reg && prog_active;

   // non-volatile content modelled as flops; reset stands for a blank array
   always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         user_option_byte_zero_reg <= OBC_ERASED;
         user_option_byte_one_reg <= OBC_ERASED;
      end else if (wr_pulse) begin
         if (obc_is_byte0(sel_sync_reg[1]))
            // reserved bits forced high so a careless tool cannot clear them
            user_option_byte_zero_reg <= {OBC_B0_RSVD, wdata_s2_reg[1:0]};
         else
            user_option_byte_one_reg <= wdata_s2_reg;
      end
   end

   // erase requested when the protect bit goes from set to clear
   always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg)
         mem_erase_req <= 1'b0;
      else
         mem_erase_req <= wr_pulse && obc_is_byte0(sel_sync_reg[1])
            && user_option_byte_zero_reg[OBC_B0_PROTECT] && !wdata_s2_reg[OBC_B0_PROTECT];
   end

   assign byte0 = ROM_VARIANT ? ROM_BYTE0 : user_option_byte_zero_reg;
   assign byte1 = ROM_VARIANT ? ROM_BYTE1 : user_option_byte_one_reg;

   always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         prog_rdata <= 8'h00;
         prog_rvalid <= 1'b0;
      end else begin
         prog_rvalid <= prog_active;
         if (!prog_active)
            prog_rdata <= 8'h00;
         else if (obc_is_byte0(sel_sync_reg[1]))
            prog_rdata <= byte0;
         else
            prog_rdata <= byte1;
      end
   end

   // irq lines registered: one cycle of latency traded for glitch-free vectors
   always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         ext_irq_vector_zero <= 1'b0;
         ext_irq_vector_one <= 1'b0;
         ext_mem_read_grant <= 1'b0;
         clock_filter_enable <= 1'b0;
         watchdog_halt_reset <= 1'b1;
         watchdog_hw_always_on <= 1'b0;
      end else begin
         if (byte0[OBC_B0_IRQMAP]) begin
            ext_irq_vector_one <= |port_b_irq || |port_c_irq;
            ext_irq_vector_zero <= |port_a_irq;
         end else begin
            ext_irq_vector_one <= |port_b_irq;
            ext_irq_vector_zero <= |port_a_irq || |port_c_irq;
         end
         ext_mem_read_grant <= ext_mem_read_req && !byte0[OBC_B0_PROTECT];
         clock_filter_enable <= !byte1[OBC_B1_CF_OFF];
         watchdog_halt_reset <= byte1[OBC_B1_WATCHDOG_HALT_RESET];
         watchdog_hw_always_on <= !byte1[OBC_B1_WATCHDOG_SOFTWARE_MODE];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg)
         oscillator_select <= OBC_CLK_EXT;
      else
         oscillator_select <= obc_osc_decode(byte1[OBC_B1_OSC_HI:OBC_B1_OSC_LO]);
   end

   always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg)
         low_voltage_threshold_select <= OBC_LV_OFF;
      else
         low_voltage_threshold_select <= obc_lvd_decode(byte1[OBC_B1_LVD_HI:OBC_B1_LVD_LO]);
   end
endmodule : obc_option_byte_config_decoder

// *** testbench/obc_chk.sv ***
`timescale 1ns/100ps
module obc_chk (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic prog_rvalid,
   input wire logic [7:0] prog_rdata,
   input wire logic [7:0] port_a_irq,
   input wire logic [7:0] port_b_irq,
   input wire logic [5:0] port_c_irq,
   input wire logic ext_irq_vector_zero,
   input wire logic ext_irq_vector_one,
   input wire logic ext_mem_read_req,
   input wire logic ext_mem_read_grant,
   input wire logic mem_erase_req,
   input wire logic clock_filter_enable,
   input wire logic watchdog_halt_reset
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   chk_one_src: assert property (ext_irq_vector_one |-> $past(|{port_b_irq, port_c_irq}))
      else $error("vector one without source");
   // internal reset sync needs a few edges before lines register
   chk_b_to_one: assert property ($past(resetn, 5) && $past(|port_b_irq) |-> ext_irq_vector_one)
      else $error("port b line lost");
   chk_zero_src: assert property (ext_irq_vector_zero |-> $past(|{port_a_irq, port_c_irq}))
      else $error("vector zero without source");
   chk_grant_req: assert property (ext_mem_read_grant |-> $past(ext_mem_read_req))
      else $error("grant without request");
   chk_erase_pulse: assert property (mem_erase_req |=> !mem_erase_req)
      else $error("erase request held");
   chk_erase_mode: assert property (mem_erase_req |-> prog_rvalid)
      else $error("erase outside programming");
   chk_rdata_shut: assert property (!prog_rvalid |-> prog_rdata == 8'h00)
      else $error("option data visible");
   chk_blank_dec: assert property ($rose(resetn) |-> ##4 !clock_filter_enable && watchdog_halt_reset)
      else $error("blank decode wrong");
   cover property (mem_erase_req);
   cover property (ext_irq_vector_one && !ext_irq_vector_zero);
   cover property (ext_mem_read_grant);
endmodule : obc_chk

bind obc_option_byte_config_decoder obc_chk obc_chk_i (.*);

// *** testbench/obc_prog_tool.sv ***
`timescale 1ns/100ps
module obc_prog_tool (
   input wire logic ref_clk,
   output logic prog_mode,
   output logic prog_sel,
   output logic prog_wr,
   output logic [7:0] prog_wdata
);
   initial {prog_mode, prog_sel, prog_wr, prog_wdata} = 11'h000;
   // pins are resynchronised, so each step holds four cycles
   task automatic put(input logic m, input logic s, input logic [7:0] d, input logic w);
      {prog_mode, prog_sel} = {m, s};
      prog_wdata = s ? d : {6'h3F, d[1:0]};
      repeat (4) @(negedge ref_clk);
      prog_wr = w;
      repeat (4) @(negedge ref_clk);
      prog_wr = 1'h0;
      repeat (4) @(negedge ref_clk);
   endtask : put
endmodule : obc_prog_tool

// *** testbench/obc_option_byte_config_decoder_bench.sv ***
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_count++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module obc_option_byte_config_decoder_bench
   import obc_pkg::*;
;
   int err_count = 0, checks_done = 0, seed = 1, ers = 0, e0;
   logic ref_clk, resetn, prog_mode, prog_sel, prog_wr, prog_rvalid, m, p;
   logic ext_mem_read_req, ext_mem_read_grant, ext_irq_vector_zero, ext_irq_vector_one;
   logic mem_erase_req, clock_filter_enable, watchdog_halt_reset, watchdog_hw_always_on;
   logic [7:0] prog_wdata, prog_rdata, port_a_irq, port_b_irq, b1;
   logic [5:0] port_c_irq;
   obc_lvd_t low_voltage_threshold_select;
   obc_clk_src_t oscillator_select, osc_t[8] = '{OBC_CLK_HS, OBC_CLK_MS, OBC_CLK_MP,
      OBC_CLK_LP, OBC_CLK_EXT_RC, OBC_CLK_EXT_RC, OBC_CLK_INT_RC, OBC_CLK_EXT};
   localparam logic [7:0] ROM_B0 = 8'hFE;
   localparam logic [7:0] ROM_B1 = 8'hEF;
   logic rom_cf, rom_gnt;
   logic [7:0] rom_rdata;
   obc_clk_src_t rom_osc;
   obc_option_byte_config_decoder obc_option_byte_config_decoder_i (.*);
   // factory-coded twin: sees the same tool, must ignore it
   obc_option_byte_config_decoder #(.ROM_VARIANT(1'b1), .ROM_BYTE0(ROM_B0), .ROM_BYTE1(ROM_B1))
      obc_option_byte_config_decoder_rom_i (.ref_clk, .resetn, .prog_mode, .prog_sel, .prog_wr,
      .prog_wdata, .prog_rdata(rom_rdata), .prog_rvalid(), .port_a_irq, .port_b_irq, .port_c_irq,
      .ext_irq_vector_zero(), .ext_irq_vector_one(), .ext_mem_read_req,
      .ext_mem_read_grant(rom_gnt), .mem_erase_req(), .clock_filter_enable(rom_cf),
      .oscillator_select(rom_osc), .low_voltage_threshold_select(), .watchdog_halt_reset(),
      .watchdog_hw_always_on());
   obc_prog_tool obc_prog_tool_i (.*);
   always @(negedge ref_clk) ers += int'(mem_erase_req === 1'h1);
   task automatic irq_chk;
      for (int i = 0; i < 16; i++) begin
         {port_a_irq, port_b_irq, port_c_irq} = 22'($random(seed))
            & {{8{i[0]}}, {8{i[1]}}, {6{i[2]}}};
         ext_mem_read_req = i[3];
         @(negedge ref_clk);
         `CHK("v0", |port_a_irq | !m & |port_c_irq, ext_irq_vector_zero)
         `CHK("v1", |port_b_irq | m & |port_c_irq, ext_irq_vector_one)
         `CHK("gnt", i[3] & !p, ext_mem_read_grant)
         `CHK("rom gnt", i[3] & !ROM_B0[0], rom_gnt)
      end
   endtask : irq_chk
   task automatic results;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #100000 err_count++;
      results();
   end
   initial begin
      resetn = 1'h0;
      {port_a_irq, port_b_irq, port_c_irq, ext_mem_read_req, m, p} = {23'h0, 2'h3};
      repeat (10) @(negedge ref_clk);
      resetn = 1'h1;
      repeat (3) @(negedge ref_clk);
      obc_prog_tool_i.put(1'h0, 1'h1, 8'h00, 1'h1);
      `CHK("cf", 1'h0, clock_filter_enable)
      `CHK("rv off", 1'h0, prog_rvalid)
      `CHK("rd off", 8'h00, prog_rdata)
      obc_prog_tool_i.put(1'h1, 1'h1, 8'h00, 1'h0);
      `CHK("blank", 8'hFF, prog_rdata)
      `CHK("rv on", 1'h1, prog_rvalid)
      irq_chk();
      for (int k = 0; k < 3; k++) begin
         {m, p} = 2'(6'h2C >> (2 * k));
         e0 = ers;
         obc_prog_tool_i.put(1'h1, 1'h0, {6'h00, m, p}, 1'h1);
         `CHK("b0", {6'h3F, m, p}, prog_rdata)
         `CHK("erase", int'(!p), ers - e0)
         irq_chk();
      end
      for (int i = 0; i < 12; i++) begin
         b1 = i < 8 ? {i[0], 3'(i), 2'(i), 2'($random(seed))} : 8'($random(seed));
         obc_prog_tool_i.put(1'h1, 1'h1, b1, 1'h1);
         `CHK("cf", !b1[7], clock_filter_enable)
         `CHK("osc", osc_t[b1[6:4]], oscillator_select)
         `CHK("lvd", obc_lvd_t'(2'h3 - b1[3:2]), low_voltage_threshold_select)
         `CHK("halt", b1[1], watchdog_halt_reset)
         `CHK("wdg", !b1[0], watchdog_hw_always_on)
      end
      `CHK("rom rd", 8'h00, rom_rdata)
      `CHK("rom cf", !ROM_B1[7], rom_cf)
      `CHK("rom osc", osc_t[ROM_B1[6:4]], rom_osc)
      results();
   end
endmodule : obc_option_byte_config_decoder_bench
